/* rtl/lsbc_pkg.sv */
// lsbc_pkg: constants for the sample buffer control block
// assumes a single 50 MHz clock domain and a classic wishbone slave
package lsbc_pkg;

  typedef enum logic [1:0] {
    LSBC_MODE_OFF  = 2'h0,
    LSBC_MODE_FIX  = 2'h1,
    LSBC_MODE_RING = 2'h3,
    LSBC_MODE_FIFO = 2'h2
  } lsbc_mode_t;

  localparam int          LSBC_DEPTH     = 16;
  localparam int          LSBC_AW        = 4;
  localparam int          LSBC_DW        = 32;
  localparam int          LSBC_NUMW      = 17;
  localparam int          LSBC_CNTW      = 5;

  localparam logic [16:0] LSBC_NUM_MIN   = 17'h00001;
  localparam logic [16:0] LSBC_NUM_MAX   = 17'h1869f;
  localparam logic [16:0] LSBC_START_RST = 17'h00001;
  localparam logic [16:0] LSBC_STOP_RST  = 17'h1869f;

  // register byte addresses
  localparam logic [7:0]  LSBC_A_CTRL    = 8'h00;
  localparam logic [7:0]  LSBC_A_STATUS  = 8'h04;
  localparam logic [7:0]  LSBC_A_IRQ     = 8'h08;
  localparam logic [7:0]  LSBC_A_MASK    = 8'h0c;
  localparam logic [7:0]  LSBC_A_START   = 8'h10;
  localparam logic [7:0]  LSBC_A_STOP    = 8'h14;
  localparam logic [7:0]  LSBC_A_CMD     = 8'h18;
  localparam logic [7:0]  LSBC_A_RDATA   = 8'h1c;
  localparam logic [7:0]  LSBC_A_RNUM    = 8'h20;

  // ctrl fields
  localparam int          LSBC_C_MODE    = 0;
  localparam int          LSBC_C_STORE   = 2;
  localparam int          LSBC_C_MON     = 3;
  localparam int          LSBC_C_MEAS    = 4;
  localparam int          LSBC_C_PRN     = 5;
  localparam int          LSBC_C_BUS     = 6;
  localparam int          LSBC_C_SKIP    = 8;
  localparam int          LSBC_SKIPW     = 8;

  // cmd fields (write one to act)
  localparam int          LSBC_K_CLEAR   = 0;
  localparam int          LSBC_K_RSTART  = 1;
  localparam int          LSBC_K_RSTOP   = 2;
  localparam int          LSBC_K_MODEUP  = 3;
  localparam int          LSBC_K_POP     = 4;

  // interrupt bits
  localparam int          LSBC_IRQW      = 4;
  localparam int          LSBC_I_FULL    = 0;
  localparam int          LSBC_I_OVF     = 1;
  localparam int          LSBC_I_RDONE   = 2;
  localparam int          LSBC_I_DROP    = 3;

  // status fields
  localparam int          LSBC_S_FULL    = 0;
  localparam int          LSBC_S_EMPTY   = 1;
  localparam int          LSBC_S_OVF     = 2;
  localparam int          LSBC_S_RECALL  = 3;
  localparam int          LSBC_S_QUIET   = 4;
  localparam int          LSBC_S_COUNT   = 8;

endpackage

/* rtl/lsbc_buffer.sv */
// lsbc_buffer: sample buffer store, overwrite, queue and recall control
// assumes records arrive as one-cycle strobes synchronous to MCLK
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RQ1 - store mode steps off, fix, ring, fifo
// RQ2 - off mode stores no records
// RQ3 - fix fills then refuses writes
// RQ4 - ring overwrites oldest once full
// RQ5 - fifo queues records in arrival order
// RQ6 - fix/ring store only while enabled
// RQ7 - software clears before changing mode
// RQ8 - clear empties the buffer
// RQ9 - monitor switch gates monitor records
// RQ10 - recall start 1..99999, default 00001
// RQ11 - fix recall uses measurement numbers
// RQ12 - ring recall numbers oldest as 00001
// RQ13 - recall ends at stop number
// RQ14 - fix full drops store enable
// RQ15 - call measurements never stored
// RQ16 - recall only stopped, fix/ring; quiet
// RQ17 - fifo full drops, sticky overflow
// RQ18 - full/empty follow every change
module lsbc_buffer (
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        REC_VALID,
  input  wire logic [31:0] REC_DATA,
  input  wire logic        REC_MONITOR,
  input  wire logic        REC_CALL,
  output logic             OUT_VALID,
  output logic      [31:0] OUT_DATA,
  output logic      [16:0] OUT_NUM,
  output logic             FULL,
  output logic             EMPTY,
  output logic             IRQ
);

  // ==========================================================
  // state
  logic [31:0]                         mem [lsbc_pkg::LSBC_DEPTH];
  logic [lsbc_pkg::LSBC_AW-1:0]        wr_ptr;
  logic [lsbc_pkg::LSBC_AW-1:0]        rd_ptr;
  logic [lsbc_pkg::LSBC_CNTW-1:0]      count;
  lsbc_pkg::lsbc_mode_t                mode;
  logic                                store_en;
  logic                                mon_en;
  logic                                meas_run;
  logic                                prn_en;
  logic                                bus_en;
  logic [lsbc_pkg::LSBC_SKIPW-1:0]     skip;
  logic [16:0]                         rstart;
  logic [16:0]                         rstop;
  logic                                ovf;
  logic [lsbc_pkg::LSBC_IRQW-1:0]      irq_stat;
  logic [lsbc_pkg::LSBC_IRQW-1:0]      irq_mask;
  logic                                recall;
  logic [16:0]                         rcur;
  logic [lsbc_pkg::LSBC_SKIPW-1:0]     skip_cnt;
  logic [16:0]                         base_num;
  logic                                pop_pend;
  logic [31:0]                         pop_data;

  // ==========================================================
  // bus decode
  logic bus_req;
  logic wr_ok;
  logic cmd_wr;
  logic clear;
  assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_ok   = bus_req && WB_WE_I && WB_SEL_I[0];
  assign cmd_wr  = wr_ok && WB_ADR_I == lsbc_pkg::LSBC_A_CMD;
  // RQ8 clear empties buffer
  assign clear   = cmd_wr && WB_DAT_I[lsbc_pkg::LSBC_K_CLEAR];

  // ==========================================================
  // record acceptance
  logic full_now;
  logic accept;
  logic do_write;
  logic overwrite;
  logic do_pop;
  logic fix_fill;
  assign full_now = count == lsbc_pkg::LSBC_CNTW'(lsbc_pkg::LSBC_DEPTH);
  // RQ2 RQ6 RQ9 RQ15 acceptance gating
  assign accept   = REC_VALID && !REC_CALL && (!REC_MONITOR || mon_en) && !clear &&
                    (mode == lsbc_pkg::LSBC_MODE_FIFO ||
                     ((mode == lsbc_pkg::LSBC_MODE_FIX || mode == lsbc_pkg::LSBC_MODE_RING) && store_en));
  // RQ3 RQ17 refuse when full
  assign do_write = accept && (!full_now || mode == lsbc_pkg::LSBC_MODE_RING);
  // RQ4 ring overwrite oldest
  assign overwrite = do_write && full_now;
  assign do_pop   = cmd_wr && WB_DAT_I[lsbc_pkg::LSBC_K_POP] && mode == lsbc_pkg::LSBC_MODE_FIFO &&
                    count != '0 && !clear;
  assign fix_fill = do_write && mode == lsbc_pkg::LSBC_MODE_FIX &&
                    count == lsbc_pkg::LSBC_CNTW'(lsbc_pkg::LSBC_DEPTH - 1);

  // RQ5 fifo storage order
  always_ff @(posedge MCLK) begin
    if (do_write) begin
      mem[wr_ptr] <= REC_DATA;
    end
  end

  // RQ18 pointers and count
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_write) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (overwrite || do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_write && !overwrite && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_write) begin
        count <= count - 1'b1;
      end
    end
  end

  // RQ11 fix numbers from measurement; RQ12 ring oldest is one
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      base_num <= lsbc_pkg::LSBC_NUM_MIN;
    end else if (clear) begin
      base_num <= lsbc_pkg::LSBC_NUM_MIN;
    end else if (overwrite) begin
      base_num <= base_num + 1'b1;
    end
  end

  // ==========================================================
  // control register writes
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode     <= lsbc_pkg::LSBC_MODE_OFF;
      store_en <= 1'b0;
      mon_en   <= 1'b1;
      meas_run <= 1'b0;
      prn_en   <= 1'b0;
      bus_en   <= 1'b0;
      skip     <= '0;
    end else begin
      if (wr_ok && WB_ADR_I == lsbc_pkg::LSBC_A_CTRL) begin
        store_en <= WB_DAT_I[lsbc_pkg::LSBC_C_STORE];
        mon_en   <= WB_DAT_I[lsbc_pkg::LSBC_C_MON];
        meas_run <= WB_DAT_I[lsbc_pkg::LSBC_C_MEAS];
        prn_en   <= WB_DAT_I[lsbc_pkg::LSBC_C_PRN];
        bus_en   <= WB_DAT_I[lsbc_pkg::LSBC_C_BUS];
        skip     <= WB_DAT_I[lsbc_pkg::LSBC_C_SKIP +: lsbc_pkg::LSBC_SKIPW];
      end
      // RQ1 mode step sequence
      if (cmd_wr && WB_DAT_I[lsbc_pkg::LSBC_K_MODEUP]) begin
        // RQ7 software clears first
        unique case (mode)
          lsbc_pkg::LSBC_MODE_OFF:  mode <= lsbc_pkg::LSBC_MODE_FIX;
          lsbc_pkg::LSBC_MODE_FIX:  mode <= lsbc_pkg::LSBC_MODE_RING;
          lsbc_pkg::LSBC_MODE_RING: mode <= lsbc_pkg::LSBC_MODE_FIFO;
          lsbc_pkg::LSBC_MODE_FIFO: mode <= lsbc_pkg::LSBC_MODE_OFF;
        endcase
      end
      // RQ14 fix full drops enable
      if (fix_fill) begin
        store_en <= 1'b0;
      end
    end
  end

  // RQ10 recall numbers range
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rstart <= lsbc_pkg::LSBC_START_RST;
      rstop  <= lsbc_pkg::LSBC_STOP_RST;
    end else begin
      if (wr_ok && WB_ADR_I == lsbc_pkg::LSBC_A_START &&
          WB_DAT_I[16:0] >= lsbc_pkg::LSBC_NUM_MIN && WB_DAT_I[16:0] <= lsbc_pkg::LSBC_NUM_MAX) begin
        rstart <= WB_DAT_I[16:0];
      end
      if (wr_ok && WB_ADR_I == lsbc_pkg::LSBC_A_STOP &&
          WB_DAT_I[16:0] >= lsbc_pkg::LSBC_NUM_MIN && WB_DAT_I[16:0] <= lsbc_pkg::LSBC_NUM_MAX) begin
        rstop <= WB_DAT_I[16:0];
      end
    end
  end

  // ==========================================================
  // recall engine
  logic rec_go;
  logic [16:0] roff;
  logic [16:0] num_lo;
  logic in_buf;
  logic quiet;
  // RQ16 recall only when stopped
  assign rec_go = cmd_wr && WB_DAT_I[lsbc_pkg::LSBC_K_RSTART] && !meas_run &&
                  (mode == lsbc_pkg::LSBC_MODE_FIX || mode == lsbc_pkg::LSBC_MODE_RING);
  // RQ12 ring numbers count from the oldest entry
  assign num_lo = mode == lsbc_pkg::LSBC_MODE_RING ? lsbc_pkg::LSBC_NUM_MIN : base_num;
  assign roff   = rcur - num_lo;
  assign in_buf = rcur >= num_lo && roff < 17'(count);
  assign quiet  = prn_en && bus_en;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      recall    <= 1'b0;
      rcur      <= lsbc_pkg::LSBC_NUM_MIN;
      skip_cnt  <= '0;
      OUT_VALID <= 1'b0;
      OUT_DATA  <= '0;
      OUT_NUM   <= '0;
    end else begin
      OUT_VALID <= 1'b0;
      if (rec_go) begin
        recall   <= 1'b1;
        rcur     <= rstart;
        skip_cnt <= '0;
      end else if (recall) begin
        // RQ13 stop number ends recall
        if (clear || meas_run || (cmd_wr && WB_DAT_I[lsbc_pkg::LSBC_K_RSTOP]) ||
            rcur > rstop || !in_buf) begin
          recall <= 1'b0;
        end else begin
          rcur <= rcur + 1'b1;
          // RQ11 skip count only fix
          if (mode == lsbc_pkg::LSBC_MODE_FIX && skip_cnt != skip) begin
            skip_cnt <= skip_cnt + 1'b1;
          end else begin
            skip_cnt  <= '0;
            // RQ16 both outputs on: silent
            OUT_VALID <= !quiet;
            OUT_DATA  <= mem[rd_ptr + roff[lsbc_pkg::LSBC_AW-1:0]];
            OUT_NUM   <= mode == lsbc_pkg::LSBC_MODE_RING ? roff + 1'b1 : rcur;
          end
        end
      end
    end
  end

  // ==========================================================
  // fifo pop latch, overflow and interrupts
  logic [lsbc_pkg::LSBC_IRQW-1:0] ev;
  logic recall_end;
  assign recall_end = recall && !rec_go && (clear || meas_run || rcur > rstop || !in_buf ||
                      (cmd_wr && WB_DAT_I[lsbc_pkg::LSBC_K_RSTOP]));
  always_comb begin
    ev = '0;
    ev[lsbc_pkg::LSBC_I_FULL]  = do_write && !full_now && count == lsbc_pkg::LSBC_CNTW'(lsbc_pkg::LSBC_DEPTH - 1);
    ev[lsbc_pkg::LSBC_I_OVF]   = accept && full_now && mode == lsbc_pkg::LSBC_MODE_FIFO;
    ev[lsbc_pkg::LSBC_I_RDONE] = recall_end;
    ev[lsbc_pkg::LSBC_I_DROP]  = accept && !do_write && mode == lsbc_pkg::LSBC_MODE_FIX;
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pop_data <= '0;
      pop_pend <= 1'b0;
    end else if (do_pop) begin
      pop_data <= mem[rd_ptr];
      pop_pend <= 1'b1;
    end else if (clear) begin
      pop_pend <= 1'b0;
    end
  end

  // RQ17 sticky overflow until clear
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ovf <= 1'b0;
    end else if (ev[lsbc_pkg::LSBC_I_OVF]) begin
      ovf <= 1'b1;
    end else if (clear) begin
      ovf <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_stat <= '0;
      irq_mask <= '0;
      IRQ      <= 1'b0;
    end else begin
      // set wins over write-one-to-clear
      if (wr_ok && WB_ADR_I == lsbc_pkg::LSBC_A_IRQ) begin
        irq_stat <= (irq_stat & ~WB_DAT_I[lsbc_pkg::LSBC_IRQW-1:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      if (wr_ok && WB_ADR_I == lsbc_pkg::LSBC_A_MASK) begin
        irq_mask <= WB_DAT_I[lsbc_pkg::LSBC_IRQW-1:0];
      end
      IRQ <= |(irq_stat & irq_mask);
    end
  end

  // RQ18 flags from next count
  logic [lsbc_pkg::LSBC_CNTW-1:0] next_count;
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (do_write && !overwrite && !do_pop) begin
      next_count = count + 1'b1;
    end else if (do_pop && !do_write) begin
      next_count = count - 1'b1;
    end
  end
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FULL  <= 1'b0;
      EMPTY <= 1'b1;
    end else begin
      FULL  <= next_count == lsbc_pkg::LSBC_CNTW'(lsbc_pkg::LSBC_DEPTH);
      EMPTY <= next_count == '0;
    end
  end

  // ==========================================================
  // wishbone read and ack
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (WB_ADR_I)
      lsbc_pkg::LSBC_A_CTRL: begin
        rd_mux[lsbc_pkg::LSBC_C_MODE +: 2] = mode;
        rd_mux[lsbc_pkg::LSBC_C_STORE]     = store_en;
        rd_mux[lsbc_pkg::LSBC_C_MON]       = mon_en;
        rd_mux[lsbc_pkg::LSBC_C_MEAS]      = meas_run;
        rd_mux[lsbc_pkg::LSBC_C_PRN]       = prn_en;
        rd_mux[lsbc_pkg::LSBC_C_BUS]       = bus_en;
        rd_mux[lsbc_pkg::LSBC_C_SKIP +: lsbc_pkg::LSBC_SKIPW] = skip;
      end
      lsbc_pkg::LSBC_A_STATUS: begin
        rd_mux[lsbc_pkg::LSBC_S_FULL]   = full_now;
        rd_mux[lsbc_pkg::LSBC_S_EMPTY]  = count == '0;
        rd_mux[lsbc_pkg::LSBC_S_OVF]    = ovf;
        rd_mux[lsbc_pkg::LSBC_S_RECALL] = recall;
        rd_mux[lsbc_pkg::LSBC_S_QUIET]  = quiet;
        rd_mux[lsbc_pkg::LSBC_S_COUNT +: lsbc_pkg::LSBC_CNTW] = count;
      end
      lsbc_pkg::LSBC_A_IRQ:   rd_mux[lsbc_pkg::LSBC_IRQW-1:0] = irq_stat;
      lsbc_pkg::LSBC_A_MASK:  rd_mux[lsbc_pkg::LSBC_IRQW-1:0] = irq_mask;
      lsbc_pkg::LSBC_A_START: rd_mux[16:0] = rstart;
      lsbc_pkg::LSBC_A_STOP:  rd_mux[16:0] = rstop;
      lsbc_pkg::LSBC_A_RDATA: rd_mux = pop_pend ? pop_data : '0;
      lsbc_pkg::LSBC_A_RNUM:  rd_mux[16:0] = rcur;
      default:                rd_mux = '0;
    endcase
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= bus_req;
      if (bus_req && !WB_WE_I) begin
        WB_DAT_O <= rd_mux;
      end
    end
  end

  // ==========================================================
  // checks
  property p_off_nostore;
    @(posedge MCLK) disable iff (SYS_RST)
      mode == lsbc_pkg::LSBC_MODE_OFF |-> !do_write;
  endproperty
  a_off_nostore: assert property (p_off_nostore) else $error("write in off mode"); // RQ2

  property p_fix_refuse;
    @(posedge MCLK) disable iff (SYS_RST)
      (mode == lsbc_pkg::LSBC_MODE_FIX && full_now && !clear) |=> $stable(wr_ptr);
  endproperty
  a_fix_refuse: assert property (p_fix_refuse) else $error("fix wrote when full"); // RQ3

  property p_ring_over;
    @(posedge MCLK) disable iff (SYS_RST)
      (mode == lsbc_pkg::LSBC_MODE_RING && full_now && accept) |=> full_now && rd_ptr == $past(rd_ptr) + 1'b1;
  endproperty
  a_ring_over: assert property (p_ring_over) else $error("ring overwrite wrong"); // RQ4

  property p_store_en;
    @(posedge MCLK) disable iff (SYS_RST)
      (REC_VALID && mode != lsbc_pkg::LSBC_MODE_FIFO && !store_en) |-> !do_write;
  endproperty
  a_store_en: assert property (p_store_en) else $error("stored while disabled"); // RQ6

  property p_clear;
    @(posedge MCLK) disable iff (SYS_RST)
      clear |=> count == '0 && EMPTY;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not empty"); // RQ8

  property p_no_call;
    @(posedge MCLK) disable iff (SYS_RST)
      REC_CALL |-> !do_write;
  endproperty
  a_no_call: assert property (p_no_call) else $error("call record stored"); // RQ15

  property p_fix_full_off;
    @(posedge MCLK) disable iff (SYS_RST)
      fix_fill |=> !store_en && full_now;
  endproperty
  a_fix_full_off: assert property (p_fix_full_off) else $error("store enable kept"); // RQ14

  property p_ovf;
    @(posedge MCLK) disable iff (SYS_RST)
      ev[lsbc_pkg::LSBC_I_OVF] |=> ovf && $stable(wr_ptr);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // RQ17

  property p_recall_run;
    @(posedge MCLK) disable iff (SYS_RST)
      meas_run |=> !recall;
  endproperty
  a_recall_run: assert property (p_recall_run) else $error("recall while measuring"); // RQ16

  property p_flags;
    @(posedge MCLK) disable iff (SYS_RST)
      ##1 (FULL == full_now) && (EMPTY == (count == '0));
  endproperty
  a_flags: assert property (p_flags) else $error("flags lag count"); // RQ18

endmodule
`default_nettype wire

/* testbench/lsbc_scan_model.sv */
// lsbc_scan_model: stand-in for the scan engine that feeds records
// assumes one record per req pulse, all on the bench clock
`timescale 1ns/1ps
`default_nettype none
module lsbc_scan_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic [31:0] req_data,
  input  wire logic        req_mon,
  input  wire logic        req_call,
  output logic             rec_valid,
  output logic      [31:0] rec_data,
  output logic             rec_monitor,
  output logic             rec_call
);
  // ==========================================================
  // record strobe
  // one-cycle strobe; data line toggles while no record is offered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rec_valid   <= 1'b0;
      rec_data    <= 32'h0;
      rec_monitor <= 1'b0;
      rec_call    <= 1'b0;
    end else if (req) begin
      rec_valid   <= 1'b1;
      rec_data    <= req_data;
      rec_monitor <= req_mon;
      rec_call    <= req_call;
    end else begin
      rec_valid   <= 1'b0;
      rec_data    <= ~rec_data;
      rec_monitor <= ~rec_monitor;
      rec_call    <= ~rec_call;
    end
  end
endmodule
`default_nettype wire

/* testbench/test_logger_sample_buffer_control.sv */
// test_logger_sample_buffer_control: self-checking bench for lsbc_buffer
// assumes lsbc_pkg and lsbc_scan_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_logger_sample_buffer_control;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h0;
  logic [31:0] dwr = 32'h0;
  logic [31:0] drd;
  logic        ack;
  logic        req = 1'b0;
  logic [31:0] req_data = 32'h0;
  logic        req_mon = 1'b0;
  logic        req_call = 1'b0;
  logic        rv, rmon, rcall, ov, full, empty, irq, i0;
  logic [31:0] rd32, od, rdv, seed;
  logic [16:0] onum;
  logic [31:0] recs[$];
  logic [31:0] qd[$];
  logic [16:0] qn[$];
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc_cnt = 0;
  int          mpos = 0;
  lsbc_pkg::lsbc_mode_t seq[4] = '{lsbc_pkg::LSBC_MODE_FIX, lsbc_pkg::LSBC_MODE_RING,
                                   lsbc_pkg::LSBC_MODE_FIFO, lsbc_pkg::LSBC_MODE_OFF};

  always #10 mclk = ~mclk;

  lsbc_buffer u_lsbc_buffer (.MCLK(mclk), .SYS_RST(sys_rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dwr), .WB_DAT_O(drd),
    .WB_ACK_O(ack), .REC_VALID(rv), .REC_DATA(rd32), .REC_MONITOR(rmon), .REC_CALL(rcall),
    .OUT_VALID(ov), .OUT_DATA(od), .OUT_NUM(onum), .FULL(full), .EMPTY(empty), .IRQ(irq));

  lsbc_scan_model u_lsbc_scan_model (.clk(mclk), .rst(sys_rst), .req(req), .req_data(req_data),
    .req_mon(req_mon), .req_call(req_call), .rec_valid(rv), .rec_data(rd32),
    .rec_monitor(rmon), .rec_call(rcall));

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic give_verdict;
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dwr <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    rdv = drd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(rdv & m, e);
  endtask

  task automatic cmd(input int b);
    wb(1'b1, lsbc_pkg::LSBC_A_CMD, 32'h1 << b);
  endtask

  task automatic send(input logic [31:0] d, input logic m, input logic c);
    @(posedge mclk);
    req      <= 1'b1;
    req_data <= d;
    req_mon  <= m;
    req_call <= c;
    @(posedge mclk);
    req <= 1'b0;
  endtask

  task automatic fill(input int n);
    repeat (n) begin
      seed = lfsr(seed);
      recs.push_back(seed);
      send(seed, 1'b0, 1'b0);
    end
    repeat (2) @(posedge mclk);
  endtask

  task automatic goto(input int m);
    cmd(lsbc_pkg::LSBC_K_CLEAR);
    while (mpos != m) begin
      cmd(lsbc_pkg::LSBC_K_MODEUP);
      mpos = (mpos + 1) % 4;
    end
    recs.delete();
  endtask

  task automatic recall;
    int k;
    qn.delete();
    qd.delete();
    cmd(lsbc_pkg::LSBC_K_RSTART);
    k = 0;
    do begin
      wb(1'b0, lsbc_pkg::LSBC_A_STATUS, 32'h0);
      k++;
    end while (rdv[3] !== 1'b0 && k < 100);
  endtask

  always @(posedge mclk) begin
    if (ov === 1'b1) begin
      qn.push_back(onum);
      qd.push_back(od);
    end
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      err_total++;
      give_verdict;
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h1448;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rchk(lsbc_pkg::LSBC_A_CTRL, 32'hffff, 32'h8);
    rchk(lsbc_pkg::LSBC_A_STATUS, 32'h1f07, 32'h2);
    rchk(lsbc_pkg::LSBC_A_START, 32'h1ffff, 32'h1);
    rchk(lsbc_pkg::LSBC_A_STOP, 32'h1ffff, 32'h1869f);
    rchk(8'h40, 32'hffffffff, 32'h0);
    for (int i = 0; i < 4; i++) begin
      cmd(lsbc_pkg::LSBC_K_MODEUP);
      rchk(lsbc_pkg::LSBC_A_CTRL, 32'h3, {30'h0, seq[i]});
    end
    wb(1'b1, lsbc_pkg::LSBC_A_CTRL, 32'hc);
    fill(3);
    check({31'h0, empty}, 32'h1);
    goto(1);
    wb(1'b1, lsbc_pkg::LSBC_A_CTRL, 32'h8);
    fill(2);
    check({31'h0, empty}, 32'h1);
    wb(1'b1, lsbc_pkg::LSBC_A_CTRL, 32'hc);
    send(32'h5a5a0001, 1'b0, 1'b1);
    fill(0);
    check({31'h0, empty}, 32'h1);
    wb(1'b1, lsbc_pkg::LSBC_A_CTRL, 32'h4);
    send(32'h5a5a0002, 1'b1, 1'b0);
    fill(0);
    check({31'h0, empty}, 32'h1);
    fill(1);
    rchk(lsbc_pkg::LSBC_A_STATUS, 32'h1f03, 32'h100);
    wb(1'b1, lsbc_pkg::LSBC_A_CTRL, 32'hc);
    fill(16);
    rchk(lsbc_pkg::LSBC_A_STATUS, 32'h1f03, 32'h1001);
    rchk(lsbc_pkg::LSBC_A_CTRL, 32'h4, 32'h0);
    rchk(lsbc_pkg::LSBC_A_IRQ, 32'h1, 32'h1);
    wb(1'b1, lsbc_pkg::LSBC_A_MASK, 32'h0);
    i0 = irq;
    wb(1'b1, lsbc_pkg::LSBC_A_MASK, 32'hf);
    check({31'h0, i0 ^ irq}, 32'h1);
    wb(1'b1, lsbc_pkg::LSBC_A_IRQ, 32'hf);
    rchk(lsbc_pkg::LSBC_A_IRQ, 32'hf, 32'h0);
    check({31'h0, irq}, 32'h0);
    wb(1'b1, lsbc_pkg::LSBC_A_STOP, 32'h3);
    recall;
    check(qn.size(), 32'h3);
    for (int i = 0; i < qn.size() && i < 3; i++) begin
      check({15'h0, qn[i]}, i + 1);
      check(qd[i], recs[i + 2]);
    end
    cmd(lsbc_pkg::LSBC_K_CLEAR);
    check({30'h0, full, empty}, 32'h1);
    goto(2);
    wb(1'b1, lsbc_pkg::LSBC_A_CTRL, 32'h2c);
    fill(20);
    check({30'h0, full, empty}, 32'h2);
    wb(1'b1, lsbc_pkg::LSBC_A_START, 32'h0);
    wb(1'b1, lsbc_pkg::LSBC_A_START, 32'h186a0);
    rchk(lsbc_pkg::LSBC_A_START, 32'h1ffff, 32'h1);
    wb(1'b1, lsbc_pkg::LSBC_A_STOP, 32'h3);
    recall;
    check(qn.size(), 32'h3);
    for (int i = 0; i < qn.size() && i < 3; i++) begin
      check({15'h0, qn[i]}, i + 1);
      check(qd[i], recs[i + 4]);
    end
    wb(1'b1, lsbc_pkg::LSBC_A_CTRL, 32'h6c);
    recall;
    check(qn.size(), 32'h0);
    wb(1'b1, lsbc_pkg::LSBC_A_CTRL, 32'h3c);
    recall;
    check(qn.size(), 32'h0);
    goto(3);
    wb(1'b1, lsbc_pkg::LSBC_A_CTRL, 32'h8);
    fill(17);
    rchk(lsbc_pkg::LSBC_A_STATUS, 32'h5, 32'h5);
    for (int i = 0; i < 16; i++) begin
      cmd(lsbc_pkg::LSBC_K_POP);
      rchk(lsbc_pkg::LSBC_A_RDATA, 32'hffffffff, recs[i]);
    end
    rchk(lsbc_pkg::LSBC_A_STATUS, 32'h7, 32'h6);
    cmd(lsbc_pkg::LSBC_K_CLEAR);
    rchk(lsbc_pkg::LSBC_A_STATUS, 32'h7, 32'h2);
    give_verdict;
  end
endmodule
`default_nettype wire
